// ==== rtl/adc_scan_defines.vh ====
// register map, field positions, reset values and timing counts
// for the scan sequencer; included by the sequencer rtl and the test bench
`ifndef ADC_SCAN_DEFINES_VH
`define ADC_SCAN_DEFINES_VH

// byte addresses
`define REG_CTRL        5'h00
`define REG_INTERVAL    5'h04
`define REG_STATUS      5'h08
`define REG_MASK        5'h0C
`define REG_RESULT      5'h10
`define REG_DOUT        5'h14
`define REG_DIN         5'h18
`define REG_CNT1        5'h1C

// control fields
`define CTRL_RUN        0
`define CTRL_SCAN       1
`define CTRL_EXT        2
`define CTRL_SWCONV     3
`define CTRL_CH_LO      4
`define CTRL_CH_HI      7
`define CTRL_RNG_LO     8
`define CTRL_RNG_HI     9
`define CTRL_CLR        10
`define CTRL_CNT12_EN   11

// status / mask bits
`define ST_DONE         0
`define ST_OVR          1
`define ST_NE           2
`define ST_W            3

// reset values
`define INTERVAL_RST    16'h0014
`define CTRL_RST        12'h000

// timing: clock and timebase in kHz
`define CLK_KHZ         125000
`define TB_KHZ          1000
`define TB_DIV          (`CLK_KHZ / `TB_KHZ)

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== rtl/adc_scan_seq.v ====
// multiplexed converter scan sequencer with axi4-lite registers
// assumes converter handshake on the same clock, mclk_i at 125 MHz
//
// Notes on behaviour
// - sixteen single-ended inputs muxed into one 12-bit converter, no gain.
// - conversion starts on software command or each low pulse externally.
// - results held in fifo, 16 words basic, 256 words larger variant.
// - single-channel mode converts only the chosen channel, once per interval.
// - scan mode converts start channel, then downward to 0, then restarts.
// - with the internal counter, scan conversions are separated by exactly one sample interval.
// - three 16-bit counters; counter 0 paces samples, others general.
// - one conversion pulse per interval, internal counter or external input.
// - interval counter ticks from a 1 MHz timebase, one count per us.
// - four input ranges: 0-5 V, 0-10 V, +-2.5 V, +-5 V.
// - one 8-bit input port and one 8-bit output port.
// - ports have no handshake; port 0 output only, port 1 input only.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_defines.vh"
module adc_scan_seq #(
    parameter FIFO_AW = 4
) (
    input  wire        mclk_i,
    input  wire        rst_i,
    // axi4-lite
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // converter
    output reg  [3:0]  adc_mux_sel_o,
    output reg  [1:0]  adc_range_o,
    output reg         adc_start_o,
    input  wire        adc_done_i,
    input  wire [11:0] adc_data_i,
    // pins
    input  wire        external_convert_n_i,
    input  wire [7:0]  din_i,
    output reg  [7:0]  dout_o,
    output reg         irq_o
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg       ext_s1_reg;
    reg       ext_s2_reg;
    reg       ext_s3_reg;
    reg [7:0] din_s1_reg;
    reg [7:0] din_s2_reg;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_s3_reg <= 1'b1;
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
        end else begin
            ext_s1_reg <= external_convert_n_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            din_s1_reg <= din_i;
            din_s2_reg <= din_s1_reg;
        end
    end
    wire ext_fall = ext_s3_reg & ~ext_s2_reg;

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [11:0] ctrl_reg;
    reg [15:0] interval_reg;
    reg [15:0] cnt1_load_reg;
    reg [15:0] cnt2_load_reg;
    reg [`ST_W-1:0] status_reg;
    reg [`ST_W-1:0] mask_reg;
    wire run      = ctrl_reg[`CTRL_RUN];
    wire scan_mode = ctrl_reg[`CTRL_SCAN];
    wire ext_src  = ctrl_reg[`CTRL_EXT];
    wire [3:0] start_ch = ctrl_reg[`CTRL_CH_HI:`CTRL_CH_LO];

    // ****************************************************************
    // 1 MHz timebase and three 16-bit counters
    // ****************************************************************
    reg  [6:0]  tb_div_reg;
    wire        tb_tick = ({25'h0, tb_div_reg} == `TB_DIV - 1);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tb_div_reg <= 7'h00;
        end else if (tb_tick) begin
            tb_div_reg <= 7'h00;
        end else begin
            tb_div_reg <= tb_div_reg + 7'h01;
        end
    end

    reg  [15:0] cnt_reg [0:2];
    wire [2:0]  cnt_tc;
    wire [15:0] cnt_load [0:2];
    wire [2:0]  cnt_en;
    assign cnt_load[0] = interval_reg;
    assign cnt_load[1] = cnt1_load_reg;
    assign cnt_load[2] = cnt2_load_reg;
    assign cnt_en[0]   = run & ~ext_src;
    assign cnt_en[1]   = ctrl_reg[`CTRL_CNT12_EN];
    assign cnt_en[2]   = ctrl_reg[`CTRL_CNT12_EN];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
            assign cnt_tc[gi] = cnt_en[gi] & tb_tick &
                                (cnt_reg[gi] <= 16'h0001);
            always @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    cnt_reg[gi] <= 16'h0000;
                end else if (!cnt_en[gi] || cnt_tc[gi]) begin
                    cnt_reg[gi] <= cnt_load[gi];
                end else if (tb_tick) begin
                    cnt_reg[gi] <= cnt_reg[gi] - 16'h0001;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    localparam S_IDLE = 1'b0;
    localparam S_BUSY = 1'b1;
    reg        state_reg;
    reg        run_d_reg;
    reg  [3:0] ch_reg;
    reg        sw_conv;
    wire       conv_req = run & (ext_src ? ext_fall : cnt_tc[0]);
    wire       fifo_full;
    wire       fifo_empty;
    wire [15:0] fifo_rdata;
    wire       push = (state_reg == S_BUSY) & adc_done_i;
    reg        pop;
    wire       ovr_ev = push & fifo_full;

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= S_IDLE;
            run_d_reg     <= 1'b0;
            ch_reg        <= 4'h0;
            adc_start_o   <= 1'b0;
            adc_mux_sel_o <= 4'h0;
            adc_range_o   <= 2'h0;
        end else begin
            adc_start_o <= 1'b0;
            adc_range_o <= ctrl_reg[`CTRL_RNG_HI:`CTRL_RNG_LO];
            run_d_reg   <= run;
            // first run cycle picks up a freshly written start channel
            if (!run || !run_d_reg) begin
                ch_reg <= start_ch;
            end
            case (state_reg)
                S_IDLE: begin
                    if (conv_req || sw_conv) begin
                        adc_mux_sel_o <= scan_mode ? ch_reg : start_ch;
                        adc_start_o   <= 1'b1;
                        state_reg     <= S_BUSY;
                        if (run && scan_mode) begin
                            ch_reg <= (ch_reg == 4'h0) ? start_ch
                                      : ch_reg - 4'h1;
                        end
                    end
                end
                S_BUSY: begin
                    if (adc_done_i) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    result_fifo #(
        .DW (16),
        .AW (FIFO_AW)
    ) u_fifo (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .clr_i   (ctrl_reg[`CTRL_CLR]),
        .push_i  (push),
        .wdata_i ({adc_mux_sel_o, adc_data_i}),
        .pop_i   (pop),
        .rdata_o (fifo_rdata),
        .full_o  (fifo_full),
        .empty_o (fifo_empty)
    );

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    reg        aw_have_reg;
    reg        w_have_reg;
    reg [4:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        rd_wait_reg;
    reg [4:0]  ar_addr_reg;
    wire       do_wr = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire       st_clr = do_wr && aw_addr_reg == `REG_STATUS;

    always @* begin
        sw_conv = do_wr && aw_addr_reg == `REG_CTRL &&
                  w_strb_reg[0] && w_data_reg[`CTRL_SWCONV];
    end

    always @* begin
        pop = s_axi_arvalid && s_axi_arready &&
              s_axi_araddr == `REG_RESULT;
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 5'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            ctrl_reg      <= `CTRL_RST;
            interval_reg  <= `INTERVAL_RST;
            cnt1_load_reg <= 16'h0000;
            cnt2_load_reg <= 16'h0000;
            mask_reg      <= {`ST_W{1'b0}};
            status_reg    <= {`ST_W{1'b0}};
            dout_o        <= 8'h00;
        end else begin
            s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            ctrl_reg[`CTRL_SWCONV] <= 1'b0;
            ctrl_reg[`CTRL_CLR]    <= 1'b0;
            if (do_wr) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_reg)
                    `REG_CTRL:     if (w_strb_reg[0] | w_strb_reg[1])
                                       ctrl_reg <= w_data_reg[11:0];
                    `REG_INTERVAL: interval_reg <= w_data_reg[15:0];
                    `REG_MASK:     mask_reg <= w_data_reg[`ST_W-1:0];
                    `REG_DOUT:     dout_o <= w_data_reg[7:0];
                    `REG_CNT1:     begin
                        cnt1_load_reg <= w_data_reg[15:0];
                        cnt2_load_reg <= w_data_reg[31:16];
                    end
                    `REG_STATUS, `REG_RESULT, `REG_DIN: ;
                    default:       s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // set wins over write-one-to-clear
            status_reg[`ST_DONE] <= push |
                (status_reg[`ST_DONE] & ~(st_clr & w_data_reg[`ST_DONE]));
            status_reg[`ST_OVR]  <= ovr_ev |
                (status_reg[`ST_OVR] & ~(st_clr & w_data_reg[`ST_OVR]));
            status_reg[`ST_NE]   <= ~fifo_empty;
        end
    end

    // read channel: result reads pop, data comes one cycle later
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
            rd_wait_reg   <= 1'b0;
            ar_addr_reg   <= 5'h00;
            irq_o         <= 1'b0;
        end else begin
            irq_o         <= |(status_reg & mask_reg);
            s_axi_arready <= ~rd_wait_reg & ~s_axi_rvalid & ~s_axi_arready
                             & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_wait_reg <= 1'b1;
                ar_addr_reg <= s_axi_araddr;
            end else if (rd_wait_reg) begin
                rd_wait_reg  <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (ar_addr_reg)
                    `REG_CTRL:     s_axi_rdata <= {20'h00000, ctrl_reg};
                    `REG_INTERVAL: s_axi_rdata <= {16'h0000, interval_reg};
                    `REG_STATUS:   s_axi_rdata <= {29'h0000000, status_reg};
                    `REG_MASK:     s_axi_rdata <= {29'h0000000, mask_reg};
                    `REG_RESULT:   s_axi_rdata <= {16'h0000, fifo_rdata};
                    `REG_DOUT:     s_axi_rdata <= {24'h000000, dout_o};
                    `REG_DIN:      s_axi_rdata <= {24'h000000, din_s2_reg};
                    `REG_CNT1:     s_axi_rdata <= {cnt_reg[2], cnt_reg[1]};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/result_fifo.v ====
// result buffer: synchronous fifo with registered read data
// assumes one clock; push is dropped inside the fifo when full
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter DW = 16,
    parameter AW = 4
) (
    input  wire          mclk_i,
    input  wire          rst_i,
    input  wire          clr_i,
    input  wire          push_i,
    input  wire [DW-1:0] wdata_i,
    input  wire          pop_i,
    output reg  [DW-1:0] rdata_o,
    output wire          full_o,
    output wire          empty_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [AW:0]   wptr_reg;
    reg [AW:0]   rptr_reg;

    assign empty_o = (wptr_reg == rptr_reg);
    assign full_o  = (wptr_reg[AW] != rptr_reg[AW]) &&
                     (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);

    always @(posedge mclk_i) begin
        if (push_i && !full_o) begin
            mem[wptr_reg[AW-1:0]] <= wdata_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_reg <= {(AW+1){1'b0}};
            rptr_reg <= {(AW+1){1'b0}};
            rdata_o  <= {DW{1'b0}};
        end else if (clr_i) begin
            wptr_reg <= {(AW+1){1'b0}};
            rptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (push_i && !full_o) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop_i && !empty_o) begin
                rdata_o  <= mem[rptr_reg[AW-1:0]];
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/adc_conv_model.sv ====
// behavioural 12-bit converter answering the start pulse
// assumes the sequencer clock; result is channel then a fixed pattern
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        start_i,
    input wire logic [3:0]  sel_i,
    output logic            done_o,
    output logic [11:0]     data_o
);
    int         left;
    logic [3:0] sel_reg;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            left <= 0;
            done_o <= 1'b0;
            data_o <= 12'h000;
        end else begin
            done_o <= 1'b0;
            data_o <= ~data_o; // data only valid with done
            if (start_i) begin
                left <= 20;
                sel_reg <= sel_i;
            end else if (left == 1) begin
                done_o <= 1'b1;
                data_o <= {sel_reg, 8'h3C};
                left <= 0;
            end else if (left > 1)
                left <= left - 1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/adc_scan_chk.sv ====
// port checker for the scan sequencer
// bound to adc_scan_seq; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module adc_scan_chk (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0]  adc_mux_sel_o,
    input wire logic        adc_start_o,
    input wire logic        adc_done_i
);
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // converter busy tracking
    // ****************************************
    logic busy_reg;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            busy_reg <= 1'b0;
        else if (adc_start_o)
            busy_reg <= 1'b1;
        else if (adc_done_i)
            busy_reg <= 1'b0;
    end
    // ****************************************
    // properties
    // ****************************************
    a_start_pulse: assert property (
        adc_start_o |=> !adc_start_o) else $error("start pulse too long");
    a_single_busy: assert property (
        adc_start_o |-> !busy_reg) else $error("start while converting");
    a_mux_hold: assert property (
        adc_start_o |=> $stable(adc_mux_sel_o)) else $error("mux moved");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
    a_rvalid_drop: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid repeated");
    a_err_rdata: assert property (
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    a_awready_pulse: assert property (
        s_axi_awready |=> !s_axi_awready) else $error("awready too long");
endmodule
bind adc_scan_seq adc_scan_chk chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
    .s_axi_rdata(s_axi_rdata), .adc_mux_sel_o(adc_mux_sel_o),
    .adc_start_o(adc_start_o), .adc_done_i(adc_done_i));
`default_nettype wire

// ==== testbench/multiplexed_adc_scan_sequencer_test.sv ====
// register-level bench for the scan sequencer
// assumes the rtl defines header and the converter model
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_defines.vh"
module multiplexed_adc_scan_sequencer_test;
    logic mclk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, adc_start_o;
    logic adc_done_i, external_convert_n_i, irq_o;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, adc_mux_sel_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, adc_range_o, rsp;
    logic [11:0] adc_data_i;
    logic [7:0]  din_i, dout_o;
    int num_errors, checks, cyc, starts, dones, gap, last;
    bit   scan_m[4] = '{1, 0, 0, 1};
    bit   ext_m[4]  = '{0, 0, 1, 1};
    int   ch_m[4]   = '{2, 7, 3, 1};
    adc_scan_seq #(.FIFO_AW(4)) uut (.*);
    adc_conv_model conv (.mclk_i(mclk_i), .rst_i(rst_i),
        .start_i(adc_start_o), .sel_i(adc_mux_sel_o),
        .done_o(adc_done_i), .data_o(adc_data_i));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // ****************************************
    // bus tasks and compare
    // ****************************************
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle(input int d0);
        while (dones == d0 || dones < starts) @(posedge mclk_i);
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic run_row(input int r);
        int s0, d0, ex;
        wr(`REG_CTRL, 32'h400);
        s0 = starts;
        d0 = dones;
        wr(`REG_CTRL, {20'h0, 2'b00, 2'(r), 4'(ch_m[r]), 1'b0, ext_m[r],
            scan_m[r], 1'b1});
        chk("range", 32'(r), {30'h0, adc_range_o});
        for (int i = 0; i < 3; i++) begin
            if (ext_m[r]) begin
                external_convert_n_i <= 1'b0;
                repeat (3) @(posedge mclk_i);
                external_convert_n_i <= 1'b1;
                repeat (100) @(posedge mclk_i);
            end else
                while (starts < s0 + i + 1) @(posedge mclk_i);
        end
        wr(`REG_CTRL, 32'h0);
        settle(d0);
        if (!ext_m[r]) chk("gap", 32'd2500, 32'(gap));
        chk("count", 32'(s0 + 3), 32'(starts));
        for (int i = 0; i < 3; i++) begin
            ex = scan_m[r] ? ch_m[r] - (i % (ch_m[r] + 1)) : ch_m[r];
            rd(`REG_RESULT, d);
            chk("result", {16'h0, 4'(ex), 4'(ex), 8'h3C}, d);
        end
    endtask
    task automatic swc();
        int d0;
        d0 = dones;
        wr(`REG_CTRL, 32'h8);
        settle(d0);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************
    // monitor and watchdog
    // ****************************************
    always @(posedge mclk_i) begin
        cyc++;
        if (adc_start_o === 1'b1) begin
            starts++;
            gap = cyc - last;
            last = cyc;
        end
        if (adc_done_i === 1'b1) dones++;
        if (cyc == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        external_convert_n_i = 1'b1;
        din_i = 8'hA5;
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(`REG_INTERVAL, d);
        chk("interval", 32'h14, d);
        chk("rresp ok", {30'h0, `RESP_OKAY}, {30'h0, rsp});
        rd(`REG_CTRL, d);
        chk("ctrl", 32'h0, d);
        wr(`REG_DOUT, 32'h5A);
        chk("dout", 32'h5A, {24'h0, dout_o});
        rd(`REG_DIN, d);
        chk("din", 32'hA5, d);
        wr(`REG_CNT1, 32'h12345678);
        rd(`REG_CNT1, d);
        chk("counters", 32'h12345678, d);
        wr(`REG_CTRL, 32'h800);
        repeat (300) @(posedge mclk_i);
        rd(`REG_CNT1, d);
        chk("cnt1 runs", 32'h1, {31'h0, 16'h5676 - d[15:0] < 16'h0002});
        chk("cnt2 runs", 32'h1, {31'h0, 16'h1232 - d[31:16] < 16'h0002});
        wr(5'h01, 32'h0);
        chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        rd(5'h01, d);
        chk("bad read", 32'h0, d);
        chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        $display("test registers done");
        wr(`REG_MASK, 32'h2);
        wr(`REG_INTERVAL, 32'h14);
        for (int r = 0; r < 4; r++) run_row(r);
        $display("test modes done");
        wr(`REG_CTRL, 32'h400);
        wr(`REG_STATUS, 32'h3);
        repeat (16) swc();
        rd(`REG_STATUS, d);
        chk("status full", 32'h5, d);
        chk("irq idle", 32'h0, {31'h0, irq_o});
        swc();
        rd(`REG_STATUS, d);
        chk("status overrun", 32'h7, d);
        chk("irq set", 32'h1, {31'h0, irq_o});
        wr(`REG_STATUS, 32'h2);
        rd(`REG_STATUS, d);
        chk("status cleared", 32'h5, d);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd(`REG_RESULT, d);
        chk("oldest", 32'h003C, d);
        $display("test overrun done");
        end_of_test();
    end
endmodule
`default_nettype wire
